// file: logic/scr_pkg.sv
package scr_pkg;
  // ==========================================
  // Register indices (16-bit registers)
  localparam logic [15:0] ADDR_GROUP_HIGH  = 16'h0030;
  localparam logic [15:0] ADDR_GROUP_LOW   = 16'h0031;
  localparam logic [15:0] ADDR_INCMD_HIGH  = 16'h007c;
  localparam logic [15:0] ADDR_INCMD_LOW   = 16'h007d;
  localparam logic [15:0] ADDR_OUTST_HIGH  = 16'h007e;
  localparam logic [15:0] ADDR_OUTST_LOW   = 16'h007f;
  // ==========================================
  // Link setting encodings and reset values
  localparam logic [1:0]  PARITY_NONE      = 2'h0;
  localparam logic [1:0]  PARITY_EVEN      = 2'h1;
  localparam logic [1:0]  PARITY_ODD       = 2'h2;
  localparam logic [1:0]  PARITY_RESET     = 2'h1;
  localparam logic        STOP_RESET       = 1'h0;
  localparam logic [13:0] REPLY_WAIT_MAX   = 14'h2710;
  localparam logic [13:0] REPLY_WAIT_RESET = 14'h0064;
  localparam logic [13:0] TIMEOUT_MAX      = 14'h2710;
  localparam logic [13:0] TIMEOUT_RESET    = 14'h0000;
  localparam logic [3:0]  ERR_THR_MIN      = 4'h1;
  localparam logic [3:0]  ERR_THR_MAX      = 4'ha;
  localparam logic [3:0]  ERR_THR_RESET    = 4'h3;
  // ==========================================
  // Timing
  localparam int CLK_MHZ         = 250;
  localparam int TICK_100US_NS   = 100000;
  localparam int TICK_100US_CYC  = TICK_100US_NS * CLK_MHZ / 1000;
  localparam int TICK_1MS_NS     = 1000000;
  localparam int TICK_1MS_CYC    = TICK_1MS_NS * CLK_MHZ / 1000;
  // ==========================================
  // Output status bit fields (lower register)
  localparam int OS_BUSY = 8;
  localparam int OS_MOVE = 13;
endpackage

// file: logic/scr_regmap.sv
`timescale 1ns/1ps
// Operation
// - Parity code: 0 none, 1 even, 2 odd
// - Stop setting 0 one bit, 1 two
// - Reply wait 0..10000 x 0.1 ms
// - Link settings not writable over serial link
// - Timeout after silent window, zero disables
// - Count errors, alarm at threshold 1..10
// - 32-bit items: even upper, odd lower
// - Command registers volatile, never stored
// - Accept queries sent to own group
// - Input command lower bit layout, upper reserved
// - Output status lower bit layout, read only
module scr_regmap #(
  parameter int TICK_100US = scr_pkg::TICK_100US_CYC,
  parameter int TICK_1MS   = scr_pkg::TICK_1MS_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  // Configuration tool port (not the serial link)
  input  wire logic        CFG_WE,
  input  wire logic [1:0]  CFG_PARITY,
  input  wire logic        CFG_STOP,
  input  wire logic [13:0] CFG_REPLY_WAIT,
  // Serial register access, decoded frames
  input  wire logic        REG_WE,
  input  wire logic        REG_RE,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output logic [15:0]      REG_RDATA,
  output logic             REG_RVALID,
  output logic             REG_ERR,
  // Link events
  input  wire logic [7:0]  FRAME_SLAVE,
  input  wire logic        FRAME_VALID,
  input  wire logic [7:0]  OWN_ADDR,
  input  wire logic        COMM_ERR,
  input  wire logic        ALARM_CLEAR,
  input  wire logic        REPLY_REQ,
  input  wire logic [13:0] TIMEOUT_SET,
  input  wire logic [3:0]  ERR_THR_SET,
  input  wire logic        SET_WE,
  // Motor side
  input  wire logic [13:0] MOTOR_STATUS,
  output logic [15:0]      NETWORK_INPUT_BIT,
  output logic             ADDR_MATCH,
  output logic             REPLY_GO,
  output logic [1:0]       PARITY,
  output logic             TWO_STOP,
  output logic             COMM_TIMEOUT,
  output logic             COMM_ERR_ALARM
);
  // ==========================================
  // State
  typedef struct packed {
    logic [1:0]  parity;
    logic        stop;
    logic [13:0] wait_set;
    logic [13:0] tmo_set;
    logic [3:0]  thr;
    logic [31:0] group;
    logic [15:0] network_input_bit;
    logic [13:0] status;
    logic [3:0]  err_cnt;
    logic        err_alarm;
    logic        tmo;
    logic [13:0] tmo_cnt;
    logic [13:0] wait_cnt;
    logic        waiting;
    logic        reply;
    logic [17:0] div_s;
    logic [17:0] div_m;
    logic [15:0] rdata;
    logic        rvalid;
    logic        rerr;
  } scr_state_type;

  scr_state_type st_r;
  scr_state_type st_nxt;
  logic          tick_s;
  logic          tick_m;

  function automatic logic [13:0] clip14(input logic [13:0] v,
                                         input logic [13:0] mx);
    clip14 = (v > mx) ? mx : v;
  endfunction

  initial begin
    if (TICK_100US < 1 || TICK_1MS < 1 || TICK_1MS > 262143)
      $error("scr_regmap: tick counts out of range");
  end

  assign tick_s = (st_r.div_s == 18'(TICK_100US - 1));
  assign tick_m = (st_r.div_m == 18'(TICK_1MS - 1));

  // ==========================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.rerr   = 1'b0;
    st_nxt.reply  = 1'b0;
    st_nxt.div_s  = tick_s ? 18'h0 : st_r.div_s + 18'h1;
    st_nxt.div_m  = tick_m ? 18'h0 : st_r.div_m + 18'h1;
    // Link settings only change from the tool port
    if (CFG_WE) begin
      if (CFG_PARITY <= scr_pkg::PARITY_ODD)
        st_nxt.parity = CFG_PARITY;
      st_nxt.stop = CFG_STOP;
      st_nxt.wait_set = clip14(CFG_REPLY_WAIT,
                               scr_pkg::REPLY_WAIT_MAX);
    end
    if (SET_WE) begin
      st_nxt.tmo_set = clip14(TIMEOUT_SET, scr_pkg::TIMEOUT_MAX);
      if (ERR_THR_SET >= scr_pkg::ERR_THR_MIN &&
          ERR_THR_SET <= scr_pkg::ERR_THR_MAX) begin
        st_nxt.thr = ERR_THR_SET;
        // A lowered threshold must not strand the count above it
        st_nxt.err_cnt = 4'h0;
      end
    end
    st_nxt.status = MOTOR_STATUS;
    // Register writes; upper halves of the command pair are reserved
    if (REG_WE) begin
      case (REG_ADDR)
        scr_pkg::ADDR_GROUP_HIGH: st_nxt.group[31:16] = REG_WDATA;
        scr_pkg::ADDR_GROUP_LOW:  st_nxt.group[15:0]  = REG_WDATA;
        scr_pkg::ADDR_INCMD_HIGH: st_nxt.network_input_bit = st_r.network_input_bit;
        scr_pkg::ADDR_INCMD_LOW:  st_nxt.network_input_bit = REG_WDATA;
        default:                  st_nxt.rerr = 1'b1;
      endcase
    end
    if (REG_RE) begin
      st_nxt.rvalid = 1'b1;
      case (REG_ADDR)
        scr_pkg::ADDR_GROUP_HIGH: st_nxt.rdata = st_r.group[31:16];
        scr_pkg::ADDR_GROUP_LOW:  st_nxt.rdata = st_r.group[15:0];
        scr_pkg::ADDR_INCMD_HIGH: st_nxt.rdata = 16'h0;
        scr_pkg::ADDR_INCMD_LOW:  st_nxt.rdata = st_r.network_input_bit;
        scr_pkg::ADDR_OUTST_HIGH: st_nxt.rdata = 16'h0;
        scr_pkg::ADDR_OUTST_LOW:  st_nxt.rdata = {2'h0, st_r.status};
        default: begin
          st_nxt.rdata = 16'h0;
          st_nxt.rerr  = 1'b1;
        end
      endcase
    end
    // Silence monitor counts in 1 ms steps
    if (FRAME_VALID) begin
      st_nxt.tmo_cnt = 14'h0;
    end else if (tick_m && st_r.tmo_set != 14'h0 && !st_r.tmo) begin
      st_nxt.tmo_cnt = st_r.tmo_cnt + 14'h1;
      if (st_r.tmo_cnt + 14'h1 >= st_r.tmo_set)
        st_nxt.tmo = 1'b1;
    end
    if (st_r.tmo_set == 14'h0)
      st_nxt.tmo = 1'b0;
    if (ALARM_CLEAR) begin
      st_nxt.tmo       = 1'b0;
      st_nxt.tmo_cnt   = 14'h0;
      st_nxt.err_alarm = 1'b0;
      st_nxt.err_cnt   = 4'h0;
    end
    // An error in the clear cycle still counts: the set wins
    if (COMM_ERR) begin
      if (st_nxt.err_cnt + 4'h1 >= st_r.thr) begin
        st_nxt.err_alarm = 1'b1;
        st_nxt.err_cnt   = 4'h0;
      end else begin
        st_nxt.err_cnt = st_nxt.err_cnt + 4'h1;
      end
    end
    // Reply wait in 0.1 ms steps
    if (REPLY_REQ) begin
      st_nxt.waiting  = 1'b1;
      st_nxt.wait_cnt = 14'h0;
      if (st_r.wait_set == 14'h0) begin
        st_nxt.waiting = 1'b0;
        st_nxt.reply   = 1'b1;
      end
    end else if (st_r.waiting && tick_s) begin
      st_nxt.wait_cnt = st_r.wait_cnt + 14'h1;
      if (st_r.wait_cnt + 14'h1 >= st_r.wait_set) begin
        st_nxt.waiting = 1'b0;
        st_nxt.reply   = 1'b1;
      end
    end
  end

  // ==========================================
  // Registers; all command state is volatile and comes up cleared
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r          <= '0;
      st_r.parity   <= scr_pkg::PARITY_RESET;
      st_r.stop     <= scr_pkg::STOP_RESET;
      st_r.wait_set <= scr_pkg::REPLY_WAIT_RESET;
      st_r.tmo_set  <= scr_pkg::TIMEOUT_RESET;
      st_r.thr      <= scr_pkg::ERR_THR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign NETWORK_INPUT_BIT         = st_r.network_input_bit;
  assign REG_RDATA      = st_r.rdata;
  assign REG_RVALID     = st_r.rvalid;
  assign REG_ERR        = st_r.rerr;
  assign PARITY         = st_r.parity;
  assign TWO_STOP       = st_r.stop;
  assign COMM_TIMEOUT   = st_r.tmo;
  assign COMM_ERR_ALARM = st_r.err_alarm;
  assign REPLY_GO       = st_r.reply;
  // Group zero means no group membership
  assign ADDR_MATCH = (FRAME_SLAVE == OWN_ADDR) ||
                      (st_r.group != 32'h0 &&
                       {24'h0, FRAME_SLAVE} == st_r.group);

  // ==========================================
  // Checks
  chk_parity_legal: assert property (@(posedge CLK) disable iff (RST)
    st_r.parity <= scr_pkg::PARITY_ODD) else $error("bad parity");
  chk_stop_tool: assert property (@(posedge CLK) disable iff (RST)
    !CFG_WE |=> $stable(TWO_STOP)) else $error("stop changed");
  chk_wait_zero: assert property (@(posedge CLK) disable iff (RST)
    REPLY_REQ && st_r.wait_set == 14'h0 |=> REPLY_GO)
    else $error("no immediate reply");
  chk_link_locked: assert property (@(posedge CLK) disable iff (RST)
    !CFG_WE |=> $stable(PARITY)) else $error("parity changed");
  chk_tmo_off: assert property (@(posedge CLK) disable iff (RST)
    st_r.tmo_set == 14'h0 |=> !COMM_TIMEOUT)
    else $error("timeout while disabled");
  chk_err_alarm: assert property (@(posedge CLK) disable iff (RST)
    COMM_ERR && !ALARM_CLEAR && !SET_WE && st_r.err_cnt + 4'h1 >= st_r.thr
    |=> COMM_ERR_ALARM && st_r.err_cnt == 4'h0)
    else $error("alarm missed");
  chk_cnt_below: assert property (@(posedge CLK) disable iff (RST)
    st_r.err_cnt < st_r.thr) else $error("count at threshold");
  chk_group_pair: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && REG_ADDR == scr_pkg::ADDR_GROUP_HIGH
    |=> st_r.group[31:16] == $past(REG_WDATA))
    else $error("group upper lost");
  chk_status_ro: assert property (@(posedge CLK) disable iff (RST)
    REG_RE && REG_ADDR == scr_pkg::ADDR_OUTST_LOW
    |=> REG_RVALID && REG_RDATA == {2'h0, $past(st_r.status)})
    else $error("status read wrong");
  chk_incmd_wr: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && REG_ADDR == scr_pkg::ADDR_INCMD_LOW
    |=> NETWORK_INPUT_BIT == $past(REG_WDATA)) else $error("command lost");
  // Settings stay inside the ranges that the clip logic enforces
  chk_wait_clip: assert property (@(posedge CLK) disable iff (RST)
    st_r.wait_set <= scr_pkg::REPLY_WAIT_MAX)
    else $error("reply wait out of range");
  chk_tmo_clip: assert property (@(posedge CLK) disable iff (RST)
    st_r.tmo_set <= scr_pkg::TIMEOUT_MAX)
    else $error("timeout out of range");
  chk_thr_range: assert property (@(posedge CLK) disable iff (RST)
    st_r.thr >= scr_pkg::ERR_THR_MIN && st_r.thr <= scr_pkg::ERR_THR_MAX)
    else $error("threshold out of range");
  chk_wait_hold: assert property (@(posedge CLK) disable iff (RST)
    !CFG_WE |=> $stable(st_r.wait_set))
    else $error("reply wait changed");
  chk_reply_pulse: assert property (@(posedge CLK) disable iff (RST)
    REPLY_GO && !REPLY_REQ |=> !REPLY_GO)
    else $error("reply pulse too long");
  chk_frame_restart: assert property (@(posedge CLK) disable iff (RST)
    FRAME_VALID |=> st_r.tmo_cnt == 14'h0)
    else $error("silence timer not restarted");
  chk_err_count: assert property (@(posedge CLK) disable iff (RST)
    COMM_ERR && !ALARM_CLEAR && !SET_WE && st_r.err_cnt + 4'h1 < st_r.thr
    |=> st_r.err_cnt == $past(st_r.err_cnt) + 4'h1)
    else $error("error not counted");
  chk_alarm_clear: assert property (@(posedge CLK) disable iff (RST)
    ALARM_CLEAR && !COMM_ERR |=> !COMM_ERR_ALARM && st_r.err_cnt == 4'h0)
    else $error("clear missed");
  // Register map corners: reserved halves and read-only words
  chk_incmd_rsvd: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && REG_ADDR == scr_pkg::ADDR_INCMD_HIGH
    |=> $stable(NETWORK_INPUT_BIT))
    else $error("reserved half changed command");
  chk_rsvd_read: assert property (@(posedge CLK) disable iff (RST)
    REG_RE && REG_ADDR == scr_pkg::ADDR_INCMD_HIGH
    |=> REG_RDATA == 16'h0)
    else $error("reserved half not zero");
  chk_outst_high: assert property (@(posedge CLK) disable iff (RST)
    REG_RE && REG_ADDR == scr_pkg::ADDR_OUTST_HIGH
    |=> REG_RDATA == 16'h0)
    else $error("status upper not zero");
  chk_status_wr: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && REG_ADDR == scr_pkg::ADDR_OUTST_LOW
    |=> REG_ERR)
    else $error("status write accepted");
  chk_group_low: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && REG_ADDR == scr_pkg::ADDR_GROUP_LOW
    |=> st_r.group[15:0] == $past(REG_WDATA))
    else $error("group lower lost");
  chk_group_hit: assert property (@(posedge CLK) disable iff (RST)
    st_r.group != 32'h0 && {24'h0, FRAME_SLAVE} == st_r.group |-> ADDR_MATCH)
    else $error("group query ignored");
  chk_read_valid: assert property (@(posedge CLK) disable iff (RST)
    REG_RE |=> REG_RVALID)
    else $error("read not answered");
endmodule

// file: tb/scr_master_model.sv
`timescale 1ns/1ps
module scr_master_model (
  input  wire logic        CLK,
  output logic             REG_WE,
  output logic             REG_RE,
  output logic [15:0]      REG_ADDR,
  output logic [15:0]      REG_WDATA,
  input  wire logic [15:0] REG_RDATA,
  input  wire logic        REG_RVALID,
  input  wire logic        REG_ERR
);
  // ==========================================
  // Register access of the link master
  initial begin
    {REG_WE, REG_RE} = 2'h0;
    {REG_ADDR, REG_WDATA} = 32'h0;
  end
  // Idle lines flip so a stale address never looks valid
  task automatic acc(input logic we, input logic [15:0] a, d,
                     output logic [15:0] q, output logic e);
    @(negedge CLK);
    REG_WE = we;
    REG_RE = !we;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    q = REG_RDATA;
    e = we ? REG_ERR : (REG_ERR | !REG_RVALID);
    {REG_WE, REG_RE} = 2'h0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask
  // Pair sent upper then lower as two single writes, well under 16
  task automatic wr_pair(input logic [15:0] a, hi, lo,
                         output logic e);
    logic [15:0] q;
    logic        e2;
    acc(1'b1, a, hi, q, e);
    acc(1'b1, a + 16'h1, lo, q, e2);
    e = e | e2;
  endtask
endmodule

// file: tb/test_serial_command_register_map.sv
`timescale 1ns/1ps
module test_serial_command_register_map;
  logic CLK, RST, CFG_WE, CFG_STOP, REG_WE, REG_RE, REG_RVALID, REG_ERR;
  logic FRAME_VALID, COMM_ERR, ALARM_CLEAR, REPLY_REQ, SET_WE, TWO_STOP;
  logic ADDR_MATCH, REPLY_GO, COMM_TIMEOUT, COMM_ERR_ALARM, e;
  logic [1:0]  CFG_PARITY, PARITY;
  logic [3:0]  ERR_THR_SET;
  logic [7:0]  FRAME_SLAVE, OWN_ADDR;
  logic [13:0] CFG_REPLY_WAIT, TIMEOUT_SET, MOTOR_STATUS;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, NETWORK_INPUT_BIT, q, d;
  logic [16:0] lf = 17'h1343a;
  int err_total, samples_checked, n, thr;
  int mdl[int];
  int wt[3] = '{0, 5, 16383};
  scr_regmap #(.TICK_100US(2), .TICK_1MS(5)) scr_regmap_i (.*);
  scr_master_model scr_master_model_i (.*);
  // ==========================================
  // Helpers
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] rnd;
    lf = {lf[15:0], lf[16] ^ lf[13]};
    return lf[15:0];
  endfunction
  task automatic pulse(ref logic s);
    @(negedge CLK);
    s = 1'b1;
    @(negedge CLK);
    s = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a);
    scr_master_model_i.acc(1'b0, a, 16'h0, q, e);
    chk(e === 1'b0 && q === 16'(mdl[a]), "read back");
  endtask
  // ==========================================
  // Clock, watchdog, tests
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  initial begin
    #240000;
    err_total++;
    final_report();
  end
  initial begin
    {RST, CFG_WE, CFG_STOP, FRAME_VALID, COMM_ERR} = 5'h10;
    {ALARM_CLEAR, REPLY_REQ, SET_WE, CFG_PARITY} = 5'h0;
    {CFG_REPLY_WAIT, TIMEOUT_SET, MOTOR_STATUS} = 42'h0;
    ERR_THR_SET = 4'h3;
    FRAME_SLAVE = 8'h00;
    OWN_ADDR = 8'h01;
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    chk(PARITY === 2'h1, "parity reset");
    chk(TWO_STOP === 1'b0, "stop reset");
    for (int p = 0; p < 4; p++) begin
      CFG_PARITY = p[1:0];
      CFG_STOP = p[0];
      pulse(CFG_WE);
      chk(PARITY === (p == 3 ? 2'h2 : p[1:0]), "parity");
      chk(TWO_STOP === p[0], "stop");
    end
    scr_master_model_i.acc(1'b1, 16'h0000, rnd(), q, e);
    chk(PARITY === 2'h2 && TWO_STOP === 1'b1, "link via bus");
    chk(e === 1'b1, "link write refused");
    $display("link settings done");
    foreach (wt[i]) begin
      CFG_REPLY_WAIT = wt[i][13:0];
      pulse(CFG_WE);
      pulse(REPLY_REQ);
      n = 0;
      while (REPLY_GO !== 1'b1 && n < 30000) begin
        @(negedge CLK);
        n++;
      end
      thr = (wt[i] > 10000 ? 10000 : wt[i]) * 2;
      chk(n <= thr + 1 && n + 2 >= thr, "reply wait");
    end
    TIMEOUT_SET = 14'h0002;
    pulse(SET_WE);
    pulse(FRAME_VALID);
    n = 0;
    while (COMM_TIMEOUT !== 1'b1 && n < 100) begin
      @(negedge CLK);
      n++;
    end
    chk(n >= 6 && n <= 10, "timeout span");
    pulse(ALARM_CLEAR);
    thr = rnd() % 10 + 1;
    ERR_THR_SET = thr[3:0];
    TIMEOUT_SET = 14'h0000;
    pulse(SET_WE);
    repeat (40) @(negedge CLK);
    chk(COMM_TIMEOUT === 1'b0, "timeout off");
    for (int i = 1; i <= thr; i++) begin
      pulse(COMM_ERR);
      chk(COMM_ERR_ALARM === (i == thr), "err alarm");
    end
    pulse(ALARM_CLEAR);
    for (int i = 1; i < thr; i++) pulse(COMM_ERR);
    chk(COMM_ERR_ALARM === 1'b0, "count cleared");
    pulse(COMM_ERR);
    chk(COMM_ERR_ALARM === 1'b1, "alarm again");
    $display("link monitors done");
    d = rnd() % 250 + 2;
    scr_master_model_i.wr_pair(16'h0030, 16'h0, d, e);
    mdl[16'h30] = 0;
    mdl[16'h31] = d;
    mdl[16'h7c] = 0;
    mdl[16'h7e] = 0;
    rdc(16'h0030);
    rdc(16'h0031);
    FRAME_SLAVE = d[7:0];
    #1 chk(ADDR_MATCH === 1'b1, "group hit");
    FRAME_SLAVE = d[7:0] + 8'h1;
    #1 chk(ADDR_MATCH === 1'b0, "group miss");
    repeat (4) begin
      d = rnd();
      scr_master_model_i.acc(1'b1, 16'h007d, d, q, e);
      mdl[16'h7d] = d;
      chk(NETWORK_INPUT_BIT === d && e === 1'b0, "command word");
      rdc(16'h007d);
    end
    scr_master_model_i.acc(1'b1, 16'h007c, ~d, q, e);
    chk(NETWORK_INPUT_BIT === d && e === 1'b0, "reserved half");
    rdc(16'h007c);
    MOTOR_STATUS = 14'(rnd());
    mdl[16'h7f] = MOTOR_STATUS;
    rdc(16'h007f);
    rdc(16'h007e);
    scr_master_model_i.acc(1'b1, 16'h007f, rnd(), q, e);
    chk(e === 1'b1, "status write");
    scr_master_model_i.acc(1'b1, 16'h0040, rnd(), q, e);
    chk(e === 1'b1, "unmapped write");
    pulse(RST);
    mdl.delete();
    mdl[16'h31] = 0;
    chk(NETWORK_INPUT_BIT === 16'h0, "command volatile");
    rdc(16'h0031);
    $display("registers done");
    final_report();
  end
endmodule
